/* bench/svd_top_asserts.sv */
`timescale 1ns/1ps
// ****************************************************************
// port checker of the supply voltage detector
// ****************************************************************
module svd_asserts (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [3:0]  pstrb,
    input  wire logic        pslverr,
    input  wire logic        sleep_mode,
    input  wire logic        detector_enable,
    input  wire logic [3:0]  tap_select,
    input  wire logic        external_select,
    input  wire logic        detect_irq_req,
    input  wire logic        wake_request,
    input  wire logic        vector_branch,
    input  wire logic        irq
);
    logic [11:0] en_cnt_q;
    logic [11:0] en_cnt_d;
    logic        ctrl_wr;

    // cycles since the detector was enabled, saturating
    assign ctrl_wr = psel && penable && pwrite && pstrb[0] && paddr == svd_pkg::ADDR_CTRL;
    always_comb begin
        en_cnt_d = en_cnt_q;
        if (!detector_enable) begin
            en_cnt_d = 12'h000;
        end else if (en_cnt_q != 12'hfff) begin
            en_cnt_d = en_cnt_q + 12'h001;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            en_cnt_q <= 12'h000;
        end else begin
            en_cnt_q <= en_cnt_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_EXT_SEL: assert property (
        external_select == (tap_select == svd_pkg::LEVEL_EXTERNAL))
        else $error("external select does not follow trip level");
    AST_CTRL_SRC: assert property (
        $changed({detector_enable, tap_select}) |-> $past(ctrl_wr) || $past(rst))
        else $error("control outputs changed without a control write");
    AST_SETTLE: assert property (
        detect_irq_req |-> en_cnt_q >= 12'(svd_pkg::SETTLE_CYCLES))
        else $error("interrupt request before settle interval ended");
    AST_VECTOR: assert property (
        vector_branch |-> wake_request)
        else $error("vector branch without wake");
    AST_WAKE: assert property (
        wake_request |-> sleep_mode)
        else $error("wake request while awake");
    AST_STICKY: assert property (
        wake_request && !(psel && penable && pwrite) ##1 sleep_mode |-> wake_request)
        else $error("flag dropped without a write");
    AST_RESET: assert property (
        $fell(rst) |-> !detector_enable && tap_select == svd_pkg::LEVEL_RESET && !irq
                       && !detect_irq_req && !wake_request)
        else $error("outputs not at reset values");
    AST_EN_OFF: assert property (
        $fell(detector_enable) |=> !detect_irq_req)
        else $error("request stays after disable");
    AST_SLVERR: assert property (
        psel && penable |-> pslverr == ((paddr > svd_pkg::ADDR_MASK) || (paddr[1:0] != 2'h0)))
        else $error("slave error mismatch");
endmodule : svd_asserts

bind svd_top svd_asserts i_svd_asserts (
    .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pstrb(pstrb), .pslverr(pslverr), .sleep_mode(sleep_mode),
    .detector_enable(detector_enable), .tap_select(tap_select),
    .external_select(external_select), .detect_irq_req(detect_irq_req),
    .wake_request(wake_request), .vector_branch(vector_branch), .irq(irq)
);

/* bench/svd_top_bench.sv */
`timescale 1ns/1ps
// ****************************************************************
// bench of the supply voltage detector
// ****************************************************************
module svd_top_bench;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb, tap_select;
    logic        int_cmp_ge, int_cmp_le, ext_cmp_ge, ext_cmp_le, sleep_mode;
    logic        detector_enable, external_select, detect_irq_req;
    logic        detect_irq_high_priority, wake_request, vector_branch, irq, err;
    int          n_mismatch, samples_checked, cycles;

    svd_top i_svd_top (.clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .int_cmp_ge, .int_cmp_le, .ext_cmp_ge, .ext_cmp_le,
        .sleep_mode, .detector_enable, .tap_select, .external_select, .detect_irq_req,
        .detect_irq_high_priority, .wake_request, .vector_branch, .irq);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
        @(posedge clk);
    endtask : wr

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask : done

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        int_cmp_ge = 1'b0;
        int_cmp_le = 1'b0;
        ext_cmp_ge = 1'b0;
        ext_cmp_le = 1'b0;
        sleep_mode = 1'b0;
        idle(20);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            rdchk(12'(4 * i), (i == 0) ? 32'h05 : 32'h00);
        end
        chk(err, 32'h0);
        chk(pready, 32'h1);
        apb(12'h01c, 1'b0, 32'h0);
        chk(err, 32'h1);
        for (int i = 0; i < 16; i++) begin
            wr(svd_pkg::ADDR_CTRL, 32'h60 | 32'(i));
            chk(tap_select, 32'(i));
            chk(external_select, 32'(i == 15));
        end
        pstrb <= 4'he;
        wr(svd_pkg::ADDR_CTRL, 32'h13);
        pstrb <= 4'hf;
        chk(detector_enable, 32'h0);
        rdchk(svd_pkg::ADDR_CTRL, 32'h0f);
        done("reset and levels");
        wr(svd_pkg::ADDR_CTRL, 32'h00);
        wr(svd_pkg::ADDR_CTRL, 32'h03);
        wr(svd_pkg::ADDR_CTRL, 32'h13);
        chk(detector_enable, 32'h1);
        int_cmp_le <= 1'b1;
        idle(100);
        int_cmp_le <= 1'b0;
        idle(1300);
        rdchk(svd_pkg::ADDR_CTRL, 32'h13);
        idle(700);
        rdchk(svd_pkg::ADDR_CTRL, 32'h33);
        rdchk(svd_pkg::ADDR_FLAGS, 32'h0);
        rdchk(svd_pkg::ADDR_EVT, 32'h2);
        rdchk(svd_pkg::ADDR_EVT, 32'h0);
        done("settle");
        wr(svd_pkg::ADDR_FLAGS, 32'h0);
        wr(svd_pkg::ADDR_IEN, 32'h4);
        wr(svd_pkg::ADDR_CORE, 32'h80);
        wr(svd_pkg::ADDR_MASK, 32'h1);
        int_cmp_le <= 1'b1;
        idle(3);
        rdchk(svd_pkg::ADDR_FLAGS, 32'h4);
        chk(detect_irq_req, 32'h1);
        chk(irq, 32'h1);
        wr(svd_pkg::ADDR_FLAGS, 32'h0);
        rdchk(svd_pkg::ADDR_FLAGS, 32'h4);
        rdchk(svd_pkg::ADDR_EVT, 32'h1);
        idle(1);
        chk(irq, 32'h0);
        int_cmp_le <= 1'b0;
        wr(svd_pkg::ADDR_FLAGS, 32'h0);
        rdchk(svd_pkg::ADDR_FLAGS, 32'h0);
        int_cmp_ge <= 1'b1;
        idle(3);
        rdchk(svd_pkg::ADDR_FLAGS, 32'h0);
        wr(svd_pkg::ADDR_MASK, 32'h0);
        wr(svd_pkg::ADDR_CTRL, 32'h93);
        rdchk(svd_pkg::ADDR_FLAGS, 32'h4);
        chk(irq, 32'h0);
        wr(svd_pkg::ADDR_MASK, 32'h1);
        chk(irq, 32'h1);
        rdchk(svd_pkg::ADDR_EVT, 32'h1);
        done("trip and interrupt");
        int_cmp_ge <= 1'b0;
        wr(svd_pkg::ADDR_FLAGS, 32'h0);
        sleep_mode <= 1'b1;
        idle(2);
        chk(wake_request, 32'h0);
        int_cmp_ge <= 1'b1;
        idle(3);
        chk(wake_request, 32'h1);
        chk(vector_branch, 32'h1);
        wr(svd_pkg::ADDR_CORE, 32'h0);
        chk(vector_branch, 32'h0);
        chk(wake_request, 32'h1);
        wr(svd_pkg::ADDR_IEN, 32'h0);
        chk(wake_request, 32'h0);
        sleep_mode <= 1'b0;
        done("sleep");
        int_cmp_ge <= 1'b0;
        wr(svd_pkg::ADDR_FLAGS, 32'h0);
        wr(svd_pkg::ADDR_CTRL, 32'h9f);
        chk(external_select, 32'h1);
        rdchk(svd_pkg::ADDR_FLAGS, 32'h0);
        ext_cmp_ge <= 1'b1;
        idle(3);
        rdchk(svd_pkg::ADDR_FLAGS, 32'h4);
        wr(svd_pkg::ADDR_PRIO, 32'h4);
        chk(detect_irq_high_priority, 32'h1);
        wr(svd_pkg::ADDR_IEN, 32'h4);
        wr(svd_pkg::ADDR_CORE, 32'h80);
        chk(detect_irq_req, 32'h1);
        wr(svd_pkg::ADDR_CTRL, 32'h8f);
        rdchk(svd_pkg::ADDR_CTRL, 32'h8f);
        chk(detect_irq_req, 32'h0);
        rdchk(svd_pkg::ADDR_FLAGS, 32'h4);
        done("external and disable");
        rst <= 1'b1;
        idle(2);
        rst <= 1'b0;
        idle(1);
        chk(tap_select, 32'h5);
        chk(detector_enable, 32'h0);
        rdchk(svd_pkg::ADDR_FLAGS, 32'h0);
        rdchk(svd_pkg::ADDR_PRIO, 32'h0);
        done("second reset");
        report_and_stop();
    end
endmodule : svd_top_bench

/* rtl/svd_ctl_if.sv */
`timescale 1ns/1ps
// ****************************************************************
// signals shared by the detector modules
// ****************************************************************
interface svd_ctl_if;
    logic       enable;
    logic       direction;
    logic [3:0] trip_level;
    logic       stable;
    logic       trip_hit;

    modport ctl    (output enable, output direction, output trip_level,
                    input stable, input trip_hit);
    modport settle (input enable, output stable);
    modport trip   (input enable, input direction, input trip_level, output trip_hit);
endinterface : svd_ctl_if

/* rtl/svd_pkg.sv */
// ****************************************************************
// constants of the supply voltage detector
// ****************************************************************
package svd_pkg;
    // clock and settle timing
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned SETTLE_TIME_NS = 20000;
    localparam int unsigned SETTLE_CYCLES  = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETTLE_W       = 12;
    localparam logic [11:0] SETTLE_LAST    = 12'(SETTLE_CYCLES - 1);

    // register byte addresses
    localparam logic [11:0] ADDR_CTRL  = 12'h000;
    localparam logic [11:0] ADDR_CORE  = 12'h004;
    localparam logic [11:0] ADDR_FLAGS = 12'h008;
    localparam logic [11:0] ADDR_IEN   = 12'h00c;
    localparam logic [11:0] ADDR_PRIO  = 12'h010;
    localparam logic [11:0] ADDR_EVT   = 12'h014;
    localparam logic [11:0] ADDR_MASK  = 12'h018;

    // register indices
    localparam logic [2:0] IDX_CTRL  = 3'h0;
    localparam logic [2:0] IDX_CORE  = 3'h1;
    localparam logic [2:0] IDX_FLAGS = 3'h2;
    localparam logic [2:0] IDX_IEN   = 3'h3;
    localparam logic [2:0] IDX_PRIO  = 3'h4;
    localparam logic [2:0] IDX_EVT   = 3'h5;
    localparam logic [2:0] IDX_MASK  = 3'h6;
    localparam logic [2:0] IDX_NONE  = 3'h7;

    // field positions
    localparam int unsigned CTRL_DIR_BIT    = 7;
    localparam int unsigned CTRL_STABLE_BIT = 5;
    localparam int unsigned CTRL_EN_BIT     = 4;
    localparam int unsigned CORE_GIE_BIT    = 7;
    localparam int unsigned DETECT_BIT      = 2;
    localparam int unsigned EVT_TRIP_BIT    = 0;
    localparam int unsigned EVT_STABLE_BIT  = 1;

    // values after reset and codes
    localparam logic [3:0] LEVEL_RESET    = 4'h5;
    localparam logic [3:0] LEVEL_EXTERNAL = 4'hf;
    localparam logic [7:0] CORE_RESET     = 8'h00;
    localparam logic [1:0] EVT_RESET      = 2'h0;

    typedef enum logic [2:0] {
        SVD_OFF    = 3'b001,
        SVD_SETTLE = 3'b010,
        SVD_READY  = 3'b100
    } svd_state_t;
endpackage : svd_pkg

/* rtl/svd_settle.sv */
`timescale 1ns/1ps
// ****************************************************************
// reference settle timer
// ****************************************************************
module svd_settle (
    input  wire logic   clk,
    input  wire logic   rst,
    svd_ctl_if.settle   ctl
);
    svd_pkg::svd_state_t             state_q;
    svd_pkg::svd_state_t             state_d;
    logic [svd_pkg::SETTLE_W-1:0]    count_q;
    logic [svd_pkg::SETTLE_W-1:0]    count_d;

    always_comb begin
        state_d = state_q;
        count_d = count_q;
        case (state_q)
            svd_pkg::SVD_OFF: begin
                count_d = '0;
                if (ctl.enable) begin
                    state_d = svd_pkg::SVD_SETTLE;
                end
            end
            svd_pkg::SVD_SETTLE: begin
                // fixed count of SETTLE_CYCLES clk cycles, 20000 ns only with the 10 ns clock period (RULE7)
                count_d = count_q + 12'h001;
                if (!ctl.enable) begin
                    state_d = svd_pkg::SVD_OFF;
                end else if (count_q == svd_pkg::SETTLE_LAST) begin
                    state_d = svd_pkg::SVD_READY;
                end
            end
            svd_pkg::SVD_READY: begin
                if (!ctl.enable) begin
                    state_d = svd_pkg::SVD_OFF;
                end
            end
            default: begin
                state_d = svd_pkg::SVD_OFF;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= svd_pkg::SVD_OFF;
            count_q <= '0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
        end
    end

    // stable only after each full settle interval (RULE7)
    assign ctl.stable = (state_q == svd_pkg::SVD_READY);
endmodule : svd_settle

/* rtl/svd_top.sv */
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
// ****************************************************************
// supply voltage detector control, apb slave
// ****************************************************************
// Notes on behaviour
// (RULE1) enabled trip sets detect_flag
// (RULE2) 4-bit trip_level picks one of 16
// (RULE3) all ones selects external_trip_input
// (RULE4) software setup order: disable, configure, enable
// (RULE5) detect_flag at flags bit 2, software clears
// (RULE6) no interrupt before reference_stable; needs enables
// (RULE7) settle interval fixed, reference_stable low meanwhile
// (RULE8) no flag set during settle interval
// (RULE9) clearing while condition holds sets again
// (RULE10) works in sleep, trip wakes device
// (RULE11) wake vectors only with global_irq_enable
// (RULE12) reset returns registers, detector disabled
// (RULE13) direction one rises, zero falls
// (RULE14) reference_stable read-only at control bit 5
// (RULE15) control resets to 05, bit 6 zero
// (RULE16) flag sticky; wake gated by detect_irq_enable
module svd_top (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [11:0]  paddr,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [31:0]  pwdata,
    input  wire logic [3:0]   pstrb,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic         int_cmp_ge,
    input  wire logic         int_cmp_le,
    input  wire logic         ext_cmp_ge,
    input  wire logic         ext_cmp_le,
    input  wire logic         sleep_mode,
    output logic              detector_enable,
    output logic [3:0]        tap_select,
    output logic              external_select,
    output logic              detect_irq_req,
    output logic              detect_irq_high_priority,
    output logic              wake_request,
    output logic              vector_branch,
    output logic              irq
);
    // ************************************************************
    // address decode
    // ************************************************************
    function automatic logic [2:0] reg_index(input logic [11:0] addr);
        logic [2:0] idx;
        idx = svd_pkg::IDX_NONE;
        if (addr == svd_pkg::ADDR_CTRL) begin
            idx = svd_pkg::IDX_CTRL;
        end else if (addr == svd_pkg::ADDR_CORE) begin
            idx = svd_pkg::IDX_CORE;
        end else if (addr == svd_pkg::ADDR_FLAGS) begin
            idx = svd_pkg::IDX_FLAGS;
        end else if (addr == svd_pkg::ADDR_IEN) begin
            idx = svd_pkg::IDX_IEN;
        end else if (addr == svd_pkg::ADDR_PRIO) begin
            idx = svd_pkg::IDX_PRIO;
        end else if (addr == svd_pkg::ADDR_EVT) begin
            idx = svd_pkg::IDX_EVT;
        end else if (addr == svd_pkg::ADDR_MASK) begin
            idx = svd_pkg::IDX_MASK;
        end
        return idx;
    endfunction : reg_index

    // ************************************************************
    // state
    // ************************************************************
    svd_ctl_if ctl_bus ();

    logic        dir_q,    dir_d;
    logic        en_q,     en_d;
    logic [3:0]  level_q,  level_d;
    logic [7:0]  core_q,   core_d;
    logic        flag_q,   flag_d;
    logic        ien_q,    ien_d;
    logic        prio_q,   prio_d;
    logic [1:0]  evt_q,    evt_d;
    logic [1:0]  mask_q,   mask_d;
    logic        stable_q, stable_d;
    logic [31:0] rdata_q,  rdata_d;
    logic        err_q,    err_d;

    logic        setup;
    logic        access;
    logic        wr;
    logic        rd;
    logic [2:0]  setup_idx;
    logic [2:0]  access_idx;
    logic [7:0]  wbyte;
    logic        trip_set;
    logic [1:0]  evt_set;
    logic        evt_rd;
    logic        global_irq_enable;

    // ************************************************************
    // submodules
    // ************************************************************
    svd_settle i_svd_settle (
        .clk (clk),
        .rst (rst),
        .ctl (ctl_bus.settle)
    );

    svd_trip i_svd_trip (
        .ctl             (ctl_bus.trip),
        .int_cmp_ge      (int_cmp_ge),
        .int_cmp_le      (int_cmp_le),
        .ext_cmp_ge      (ext_cmp_ge),
        .ext_cmp_le      (ext_cmp_le),
        .tap_select      (tap_select),
        .external_select (external_select)
    );

    assign ctl_bus.enable     = en_q;
    assign ctl_bus.direction  = dir_q;
    assign ctl_bus.trip_level = level_q;

    // ************************************************************
    // bus phases
    // ************************************************************
    assign setup      = psel && !penable;
    assign access     = psel && penable;
    assign wr         = access && pwrite && pstrb[0];
    assign rd         = access && !pwrite;
    assign setup_idx  = reg_index(paddr);
    assign access_idx = reg_index(paddr);
    assign wbyte      = pwdata[7:0];
    assign evt_rd     = rd && (access_idx == svd_pkg::IDX_EVT);

    // trip only counts once the reference has settled (RULE8)
    assign trip_set = ctl_bus.stable && ctl_bus.trip_hit; // RULE1

    always_comb begin
        evt_set                           = 2'h0;
        evt_set[svd_pkg::EVT_TRIP_BIT]    = trip_set && !flag_q;
        evt_set[svd_pkg::EVT_STABLE_BIT]  = ctl_bus.stable && !stable_q;
    end

    // ************************************************************
    // next register values
    // ************************************************************
    always_comb begin
        dir_d    = dir_q;
        en_d     = en_q;
        level_d  = level_q;
        core_d   = core_q;
        ien_d    = ien_q;
        prio_d   = prio_q;
        mask_d   = mask_q;
        flag_d   = flag_q;
        evt_d    = evt_q;
        stable_d = ctl_bus.stable;
        if (wr) begin
            case (access_idx)
                svd_pkg::IDX_CTRL: begin
                    dir_d   = wbyte[svd_pkg::CTRL_DIR_BIT];
                    en_d    = wbyte[svd_pkg::CTRL_EN_BIT];
                    level_d = wbyte[3:0]; // RULE2
                end
                svd_pkg::IDX_CORE: begin
                    core_d = wbyte;
                end
                svd_pkg::IDX_FLAGS: begin
                    // software clear by writing zero (RULE5)
                    if (!wbyte[svd_pkg::DETECT_BIT]) begin
                        flag_d = 1'b0;
                    end
                end
                svd_pkg::IDX_IEN: begin
                    ien_d = wbyte[svd_pkg::DETECT_BIT];
                end
                svd_pkg::IDX_PRIO: begin
                    prio_d = wbyte[svd_pkg::DETECT_BIT];
                end
                svd_pkg::IDX_MASK: begin
                    mask_d = wbyte[1:0];
                end
                default: begin
                end
            endcase
        end
        // a read clears only the bits it reported; later events survive
        if (evt_rd) begin
            evt_d = evt_q & ~rdata_q[1:0];
        end
        // sets win over clears; condition still true sets again (RULE9)
        evt_d = evt_d | evt_set;
        if (trip_set) begin
            flag_d = 1'b1; // RULE16
        end
    end

    // ************************************************************
    // read data, captured in the setup phase
    // ************************************************************
    always_comb begin
        // hold the captured word until the next setup phase
        rdata_d = rdata_q;
        err_d   = err_q;
        if (setup) begin
            rdata_d = 32'h0000_0000;
            err_d   = 1'b0;
            case (setup_idx)
                svd_pkg::IDX_CTRL: begin
                    rdata_d[svd_pkg::CTRL_DIR_BIT]    = dir_q;
                    rdata_d[svd_pkg::CTRL_STABLE_BIT] = ctl_bus.stable; // RULE14
                    rdata_d[svd_pkg::CTRL_EN_BIT]     = en_q;
                    rdata_d[3:0]                      = level_q;
                end
                svd_pkg::IDX_CORE: begin
                    rdata_d[7:0] = core_q;
                end
                svd_pkg::IDX_FLAGS: begin
                    rdata_d[svd_pkg::DETECT_BIT] = flag_q;
                end
                svd_pkg::IDX_IEN: begin
                    rdata_d[svd_pkg::DETECT_BIT] = ien_q;
                end
                svd_pkg::IDX_PRIO: begin
                    rdata_d[svd_pkg::DETECT_BIT] = prio_q;
                end
                svd_pkg::IDX_EVT: begin
                    rdata_d[1:0] = evt_q;
                end
                svd_pkg::IDX_MASK: begin
                    rdata_d[1:0] = mask_q;
                end
                default: begin
                    err_d = 1'b1;
                end
            endcase
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            // control back to direction 0, off, level 0101 (RULE12)
            dir_q    <= 1'b0; // RULE15
            en_q     <= 1'b0;
            level_q  <= svd_pkg::LEVEL_RESET;
            core_q   <= svd_pkg::CORE_RESET;
            flag_q   <= 1'b0;
            ien_q    <= 1'b0;
            prio_q   <= 1'b0;
            evt_q    <= svd_pkg::EVT_RESET;
            mask_q   <= svd_pkg::EVT_RESET;
            stable_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            err_q    <= 1'b0;
        end else begin
            dir_q    <= dir_d;
            en_q     <= en_d;
            level_q  <= level_d;
            core_q   <= core_d;
            flag_q   <= flag_d;
            ien_q    <= ien_d;
            prio_q   <= prio_d;
            evt_q    <= evt_d;
            mask_q   <= mask_d;
            stable_q <= stable_d;
            rdata_q  <= rdata_d;
            err_q    <= err_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign prdata  = rdata_q;
    assign pready  = 1'b1;
    assign pslverr = access && err_q;

    // detector keeps running regardless of sleep (RULE10)
    assign detector_enable = en_q;

    // ************************************************************
    // interrupt and wake
    // ************************************************************
    assign global_irq_enable = core_q[svd_pkg::CORE_GIE_BIT];

    // interrupt only with both enables and settled reference (RULE6)
    assign detect_irq_req = flag_q && ien_q && global_irq_enable && ctl_bus.stable;
    assign detect_irq_high_priority = prio_q;

    // wake gated by detect_irq_enable only (RULE16)
    assign wake_request = sleep_mode && flag_q && ien_q; // RULE10
    // vector only when globally enabled, else continue in line (RULE11)
    assign vector_branch = wake_request && global_irq_enable;

    // level interrupt while an unmasked event bit is set
    assign irq = |(evt_q & mask_q);
endmodule : svd_top

/* rtl/svd_trip.sv */
`timescale 1ns/1ps
// ****************************************************************
// trip source select and direction qualify
// ****************************************************************
module svd_trip (
    svd_ctl_if.trip     ctl,
    input  wire logic   int_cmp_ge,
    input  wire logic   int_cmp_le,
    input  wire logic   ext_cmp_ge,
    input  wire logic   ext_cmp_le,
    output logic [3:0]  tap_select,
    output logic        external_select
);
    logic ge;
    logic le;

    always_comb begin
        // all ones routes the external pin in (RULE3)
        external_select = (ctl.trip_level == svd_pkg::LEVEL_EXTERNAL);
        tap_select      = ctl.trip_level; // RULE2
        ge              = external_select ? ext_cmp_ge : int_cmp_ge;
        le              = external_select ? ext_cmp_le : int_cmp_le;
        // rise: at or above; fall: at or below (RULE13)
        ctl.trip_hit    = ctl.enable && (ctl.direction ? ge : le);
    end
endmodule : svd_trip
